//--- scs_pkg.sv
// Operation
// - host-mode bit set selects the host clock input as primary clock.
// - in host mode the host clock feeds the halver and output selectors.
// - pci clock output buffers enabled only when the drive bit is set.
// - each pci clock output has its own enable bit in output control.
// - host mode, strap 0 drives halved sync clock, otherwise full clock.
// - with strap 0, output control selects full or halved host clock for pci outputs; strap 1 gives full.
// - agent mode uses pci clock input; pci and sync outputs unused.
// - agent mode with strap 0 doubles internal clock frequencies.
// - pci unused takes pci clock input as primary; board ties others low.
// - usb reference derived from system clock divided by one or two.
// - in transceiver mode the transceiver clocks the usb controller.
// - crossings from transceiver domain into bus domain are synchronized.
// - parallel ethernet modes use the 125 MHz gigabit transmit clock.
// - serial ethernet uses its own 125 MHz reference for its pll.
// - strap sampled while power-on reset asserted, then held.
// - host-mode and drive bits come from the high config word.
package scs_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0]  OUT_CTRL_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS        = 8'h04;
    localparam logic [31:0] OUT_CTRL_RESET    = 32'h0000_001F;

    // ==========================================================
    // output control fields
    localparam int PCI_CLOCK_OUT_EN_LSB = 0;
    localparam int PCI_HALF_SEL_BIT     = 3;
    localparam int USB_HALF_SEL_BIT     = 4;
    localparam int UTMI_MODE_BIT        = 5;
    localparam int SGMII_MODE_BIT       = 6;
    localparam int OUT_CTRL_WIDTH       = 7;

    // ==========================================================
    // high config word fields
    localparam int RESET_CONFIG_WORD_HIGH_HOST_MODE_BIT   = 8;
    localparam int RESET_CONFIG_WORD_HIGH_PCI_DRIVE_BIT   = 9;
    localparam int RESET_CONFIG_WORD_HIGH_PCI_USED_BIT    = 10;

    // ==========================================================
    // counts
    localparam int PCI_CLOCK_COUNT      = 3;
    localparam int ETH_REF_MHZ          = 125;

    typedef enum logic [1:0]
    {
        MODE_DISABLED = 2'b00,
        MODE_AGENT    = 2'b01,
        MODE_HOST     = 2'b10
    } scs_mode_t;

    typedef struct packed
    {
        logic host_mode_bit;
        logic pci_clock_drive_bit;
        logic pci_used;
    } scs_cfg_t;

endpackage : scs_pkg

//--- scs_clock_select.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module scs_clock_select
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // power-on reset and straps
    input  wire logic        power_on_reset_n,
    input  wire logic        clock_divide_strap,
    input  wire logic [31:0] reset_config_word_high,
    input  wire logic        rcw_load,
    // clock sources, sampled levels
    input  wire logic        host_clock_in,
    input  wire logic        pci_clock_in,
    input  wire logic        system_clock_in,
    input  wire logic        usb_phy_clock,
    input  wire logic        usb_phy_ready,
    input  wire logic        gigabit_tx_ref_clock,
    input  wire logic        sgmii_ref_clock,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // pci clock outputs
    output logic [2:0]       pci_clock_out,
    output logic [2:0]       pci_clock_oe,
    output logic             sync_out,
    output logic             sync_oe,
    // internal clock selection
    output logic             primary_clock,
    output logic             primary_is_host,
    output logic             internal_double,
    output logic             usb_ref_clock,
    output logic             usb_ctrl_clock,
    output logic             eth_ref_clock
);

    // ==========================================================
    // helpers
    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction : rise

    logic [scs_pkg::OUT_CTRL_WIDTH-1:0] output_clock_control_reg;
    scs_pkg::scs_cfg_t                  cfg_reg;
    scs_pkg::scs_mode_t                 mode;
    logic                               strap_reg;
    logic                               cfg_loaded_reg;
    logic                               host_q_reg;
    logic                               host_half_reg;
    logic                               sys_q_reg;
    logic                               sys_half_reg;
    logic                               phy_meta_reg;
    logic                               phy_sync_reg;
    logic                               half_sel;
    logic                               pci_src;
    logic                               sync_src;
    logic [31:0]                        rdata_next;

    // ==========================================================
    // power-on capture
    // strap tracked under reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            strap_reg <= 1'b0;
        else if (!power_on_reset_n)
            strap_reg <= clock_divide_strap;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_reg <= '0;
        else if (rcw_load && power_on_reset_n)
        begin
            cfg_reg.host_mode_bit <=
                reset_config_word_high[scs_pkg::RESET_CONFIG_WORD_HIGH_HOST_MODE_BIT];
            cfg_reg.pci_clock_drive_bit <=
                reset_config_word_high[scs_pkg::RESET_CONFIG_WORD_HIGH_PCI_DRIVE_BIT];
            cfg_reg.pci_used <=
                reset_config_word_high[scs_pkg::RESET_CONFIG_WORD_HIGH_PCI_USED_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_loaded_reg <= 1'b0;
        else if (!power_on_reset_n)
            cfg_loaded_reg <= 1'b0;
        else if (rcw_load)
            cfg_loaded_reg <= 1'b1;
    end

    // ==========================================================
    // mode decode
    // host bit wins over agent
    always_comb
    begin
        if (cfg_reg.host_mode_bit)
            mode = scs_pkg::MODE_HOST;
        else if (cfg_reg.pci_used)
            mode = scs_pkg::MODE_AGENT;
        else
            mode = scs_pkg::MODE_DISABLED;
    end

    // ==========================================================
    // register port
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            output_clock_control_reg <=
                scs_pkg::OUT_CTRL_RESET[scs_pkg::OUT_CTRL_WIDTH-1:0];
        else if (reg_write && reg_addr == scs_pkg::OUT_CTRL_OFS)
            output_clock_control_reg <=
                reg_wdata[scs_pkg::OUT_CTRL_WIDTH-1:0];
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (reg_addr == scs_pkg::OUT_CTRL_OFS)
            rdata_next[scs_pkg::OUT_CTRL_WIDTH-1:0] =
                output_clock_control_reg;
        else if (reg_addr == scs_pkg::STATUS_OFS)
            rdata_next[6:0] = {phy_sync_reg,
                               mode == scs_pkg::MODE_DISABLED,
                               internal_double, cfg_loaded_reg,
                               strap_reg, cfg_reg.pci_clock_drive_bit,
                               cfg_reg.host_mode_bit};
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_read)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 32'h0000_0000;
    end

    // ==========================================================
    // host clock halver
    // host clock feeds halver
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            host_q_reg    <= 1'b0;
            host_half_reg <= 1'b0;
        end
        else
        begin
            host_q_reg <= host_clock_in;
            if (rise(host_clock_in, host_q_reg))
                host_half_reg <= ~host_half_reg;
        end
    end

    assign sync_src = strap_reg ? host_q_reg : host_half_reg;
    // control halves pci only with strap 0
    assign half_sel = ~strap_reg &
        output_clock_control_reg[scs_pkg::PCI_HALF_SEL_BIT];
    assign pci_src = half_sel ? host_half_reg : host_q_reg;

    // ==========================================================
    // pci clock outputs, index 0 sits in the top enable bit
    genvar gi;
    generate
        for (gi = 0; gi < scs_pkg::PCI_CLOCK_COUNT; gi++)
        begin : g_pci_out
            localparam int EN_BIT = scs_pkg::PCI_CLOCK_OUT_EN_LSB
                                  + scs_pkg::PCI_CLOCK_COUNT - 1 - gi;
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    pci_clock_out[gi] <= 1'b0;
                    pci_clock_oe[gi]  <= 1'b0;
                end
                else if (mode == scs_pkg::MODE_HOST && cfg_loaded_reg
                         && power_on_reset_n
                         && cfg_reg.pci_clock_drive_bit
                         && output_clock_control_reg[EN_BIT])
                begin
                    pci_clock_out[gi] <= pci_src;
                    pci_clock_oe[gi]  <= 1'b1;
                end
                else
                begin
                    pci_clock_out[gi] <= 1'b0;
                    pci_clock_oe[gi]  <= 1'b0;
                end
            end
        end
    endgenerate

    // sync output idle outside host mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_out <= 1'b0;
            sync_oe  <= 1'b0;
        end
        else if (mode == scs_pkg::MODE_HOST && cfg_loaded_reg
                 && power_on_reset_n)
        begin
            sync_out <= sync_src;
            sync_oe  <= 1'b1;
        end
        else
        begin
            sync_out <= 1'b0;
            sync_oe  <= 1'b0;
        end
    end

    // ==========================================================
    // primary clock
    // host clock only in host mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            primary_clock   <= 1'b0;
            primary_is_host <= 1'b0;
            internal_double <= 1'b0;
        end
        else
        begin
            primary_is_host <= (mode == scs_pkg::MODE_HOST);
            primary_clock   <= (mode == scs_pkg::MODE_HOST) ?
                               host_clock_in : pci_clock_in;
            internal_double <= (mode == scs_pkg::MODE_AGENT) & ~strap_reg;
        end
    end

    // ==========================================================
    // usb clocking
    // system clock by one or two
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sys_q_reg     <= 1'b0;
            sys_half_reg  <= 1'b0;
            usb_ref_clock <= 1'b0;
        end
        else
        begin
            sys_q_reg <= system_clock_in;
            if (rise(system_clock_in, sys_q_reg))
                sys_half_reg <= ~sys_half_reg;
            usb_ref_clock <=
                output_clock_control_reg[scs_pkg::USB_HALF_SEL_BIT] ?
                sys_half_reg : sys_q_reg;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            usb_ctrl_clock <= 1'b0;
        else if (output_clock_control_reg[scs_pkg::UTMI_MODE_BIT])
            usb_ctrl_clock <= usb_phy_clock;
        else
            usb_ctrl_clock <= sys_q_reg;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phy_meta_reg <= 1'b0;
            phy_sync_reg <= 1'b0;
        end
        else
        begin
            phy_meta_reg <= usb_phy_ready;
            phy_sync_reg <= phy_meta_reg;
        end
    end

    // ==========================================================
    // ethernet reference
    // parallel vs serial reference
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            eth_ref_clock <= 1'b0;
        else if (output_clock_control_reg[scs_pkg::SGMII_MODE_BIT])
            eth_ref_clock <= sgmii_ref_clock;
        else
            eth_ref_clock <= gigabit_tx_ref_clock;
    end

endmodule : scs_clock_select

//--- scs_far_side.sv
`timescale 1ns/1ns
// ========================================
// board oscillator and sync loop
module scs_far_side
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // board setup
    input  wire logic host_board,
    input  wire logic slow,
    // device pins
    input  wire logic sync_out,
    input  wire logic sync_oe,
    output logic      host_clock_in,
    output logic      pci_clock_in
);
    logic [1:0] div_reg;

    always_ff @(posedge clk or posedge rst)
        if (rst)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    assign host_clock_in = host_board & (slow ? div_reg[1] : div_reg[0]);
    // sync looped back, pulled low when undriven
    assign pci_clock_in = host_board ? (sync_oe & sync_out) : div_reg[1];
endmodule : scs_far_side

//--- scs_clock_select_sva.sv
`timescale 1ns/1ns
// ========================================
// port relations of the selector
module scs_clock_select_sva
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // straps and sources
    input wire logic        power_on_reset_n,
    input wire logic        clock_divide_strap,
    input wire logic        host_clock_in,
    input wire logic        pci_clock_in,
    // watched outputs
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  pci_clock_oe,
    input wire logic        sync_out,
    input wire logic        sync_oe,
    input wire logic        primary_clock,
    input wire logic        primary_is_host,
    input wire logic        internal_double
);
    logic [1:0] up_reg;
    logic       strap_reg;
    logic       ok;
    logic       full_ok;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // outputs read zero just after reset, so skip those edges
    always_ff @(posedge clk or posedge rst)
        if (rst)
            up_reg <= 2'h0;
        else if (up_reg != 2'h3)
            up_reg <= up_reg + 2'h1;
    always_ff @(posedge clk)
        if (!power_on_reset_n)
            strap_reg <= clock_divide_strap;
    assign ok = (up_reg == 2'h3);
    assign full_ok = sync_oe && power_on_reset_n && strap_reg;

    a_oe_in_por: assert property (!power_on_reset_n [*2] |->
        pci_clock_oe == 3'h0 && !sync_oe) else $error("oe during por");
    a_agent_quiet: assert property ((ok && !primary_is_host) [*3] |->
        pci_clock_oe == 3'h0 && !sync_oe) else $error("agent outputs");
    a_host_source: assert property ((ok && primary_is_host) [*2] |->
        primary_clock == $past(host_clock_in)) else $error("host source");
    a_pci_source: assert property ((ok && !primary_is_host) [*2] |->
        primary_clock == $past(pci_clock_in)) else $error("pci source");
    a_double_mode: assert property (internal_double |->
        !primary_is_host) else $error("double in host");
    a_strap_held: assert property (internal_double && power_on_reset_n
        && $past(power_on_reset_n) |-> !strap_reg) else $error("strap");
    a_sync_mode: assert property (sync_oe |->
        primary_is_host || $past(primary_is_host)) else $error("sync mode");
    a_sync_full: assert property (full_ok [*2] |->
        sync_out == $past(host_clock_in, 2)) else $error("sync full");
    a_read_idle: assert property (!$past(reg_read) |->
        reg_rdata == 32'h0000_0000) else $error("read data idle");

    c_host_full: cover property (full_ok);
    c_double: cover property (internal_double);
    c_all_oe: cover property (pci_clock_oe == 3'h7);
endmodule : scs_clock_select_sva

bind scs_clock_select scs_clock_select_sva u_scs_clock_select_sva (
    .clk, .rst, .power_on_reset_n, .clock_divide_strap, .host_clock_in,
    .pci_clock_in, .reg_read, .reg_rdata, .pci_clock_oe, .sync_out,
    .sync_oe, .primary_clock, .primary_is_host, .internal_double);

//--- system_clock_source_select_tb_top.sv
`timescale 1ns/1ns
// ========================================
// bench for the clock source selector
module system_clock_source_select_tb_top;
    logic        clk, rst, power_on_reset_n, clock_divide_strap, rcw_load;
    logic        system_clock_in, usb_phy_clock, usb_phy_ready, host_board;
    logic        gigabit_tx_ref_clock, sgmii_ref_clock, reg_write, reg_read;
    logic        host_clock_in, pci_clock_in, sync_out, sync_oe;
    logic        primary_clock, primary_is_host, internal_double;
    logic        usb_ref_clock, usb_ctrl_clock, eth_ref_clock;
    logic [2:0]  pci_clock_out, pci_clock_oe, en;
    logic [7:0]  reg_addr;
    logic [31:0] reset_config_word_high, reg_wdata, reg_rdata, rd, ex;
    logic [6:0]  ctl;
    logic [4:0]  watch, prev;
    logic [3:0]  cases [7] = '{4'hA, 4'hE, 4'h6, 4'h9, 4'h5, 4'h8, 4'h0};
    int          err_total, tests_run, rises [5];

    scs_clock_select u_scs_clock_select (.clk, .rst, .power_on_reset_n,
        .clock_divide_strap, .reset_config_word_high, .rcw_load,
        .host_clock_in, .pci_clock_in, .system_clock_in, .usb_phy_clock,
        .usb_phy_ready, .gigabit_tx_ref_clock, .sgmii_ref_clock, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .pci_clock_out,
        .pci_clock_oe, .sync_out, .sync_oe, .primary_clock,
        .primary_is_host, .internal_double, .usb_ref_clock,
        .usb_ctrl_clock, .eth_ref_clock);
    scs_far_side u_scs_far_side (.clk, .rst, .host_board, .slow(1'h1),
        .sync_out, .sync_oe, .host_clock_in, .pci_clock_in);
    assign watch = {eth_ref_clock, usb_ctrl_clock, usb_ref_clock, sync_out,
                    pci_clock_out[0]};

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // phy and serdes clocks run at half rate so their paths are told apart
    // board clock rates
    always @(posedge clk)
    begin
        system_clock_in      <= ~system_clock_in;
        gigabit_tx_ref_clock <= ~gigabit_tx_ref_clock;
        if (system_clock_in)
            usb_phy_clock <= ~usb_phy_clock;
        if (!system_clock_in)
            sgmii_ref_clock <= ~sgmii_ref_clock;
    end

    function automatic int exp_rise(input int i, input logic s,
                                    input logic [6:0] c);
        case (i)
            0: return (!s && c[3]) ? 4 : 8;
            1: return s ? 8 : 4;
            2: return c[4] ? 8 : 16;
            3: return c[5] ? 8 : 16;
            default: return c[6] ? 8 : 16;
        endcase
    endfunction : exp_rise
    // edge counts may slip by one at the window ends
    function automatic int near(input int r, input int e);
        return (r - e <= 1 && e - r <= 1) ? e : r;
    endfunction : near

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk);
        reg_write <= 1'h0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk);
        reg_read <= 1'h0;
        #1 d = reg_rdata;
    endtask : reg_rd
    task automatic measure;
        repeat (3) @(posedge clk);
        #1 prev = watch;
        rises = '{default: 0};
        repeat (32)
        begin
            @(posedge clk);
            #1;
            for (int i = 0; i < 5; i++)
                rises[i] += int'(watch[i] & ~prev[i]);
            prev = watch;
            check(pci_clock_out, {3{pci_clock_out[0]}});
        end
    endtask : measure

    task automatic run_case(input logic d, input logic s, input logic [1:0] m);
        reset_config_word_high <= ($urandom & 32'hFFFF_F8FF) |
            {21'h0, m != 2'h0, d, m == 2'h2, 8'h00};
        @(posedge clk);
        power_on_reset_n   <= 1'h0;
        clock_divide_strap <= s;
        host_board         <= (m == 2'h2);
        usb_phy_ready      <= 1'($urandom);
        repeat (4) @(posedge clk);
        #1 check({pci_clock_oe, sync_oe}, 4'h0);
        @(posedge clk);
        power_on_reset_n <= 1'h1;
        @(posedge clk);
        rcw_load <= 1'h1;
        @(posedge clk);
        rcw_load <= 1'h0;
        repeat (3) @(posedge clk);
        #1 check(primary_is_host, m == 2'h2);
        check(internal_double, m == 2'h1 && !s);
        ex = {25'h0, usb_phy_ready, m == 2'h0, m == 2'h1 && !s, 1'h1, s, d,
              m == 2'h2};
        reg_rd(scs_pkg::STATUS_OFS, rd);
        check(rd, ex);
        if (m == 2'h2)
        begin
            en = 3'($urandom);
            reg_wr(scs_pkg::OUT_CTRL_OFS, {29'h0, en});
            repeat (2) @(posedge clk);
            #1 check(pci_clock_oe, d ? {en[0], en[1], en[2]} : 3'h0);
            check(sync_oe, 1'h1);
            for (int k = 0; k < 4 && d; k++)
            begin
                ctl = {k[0], k[1], k[0], k[1], 3'h7};
                reg_wr(scs_pkg::OUT_CTRL_OFS, {25'h0, ctl});
                reg_rd(scs_pkg::OUT_CTRL_OFS, rd);
                check(rd, {25'h0, ctl});
                measure();
                for (int i = 0; i < 5; i++)
                    check(near(rises[i], exp_rise(i, s, ctl)),
                          exp_rise(i, s, ctl));
            end
        end
        else
            check({pci_clock_oe, sync_oe}, 4'h0);
    endtask : run_case

    initial
    begin
        void'($urandom(32'he725_ec85));
        {rst, power_on_reset_n, clock_divide_strap, rcw_load} = 4'h8;
        {system_clock_in, usb_phy_clock, usb_phy_ready, reg_write} = 4'h0;
        {gigabit_tx_ref_clock, sgmii_ref_clock, reg_read, host_board} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reset_config_word_high = 32'h0000_0000;
        err_total = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        reg_rd(scs_pkg::OUT_CTRL_OFS, rd);
        check(rd, scs_pkg::OUT_CTRL_RESET);
        reg_wr(8'h08, 32'hFFFF_FFFF);
        reg_wr(scs_pkg::STATUS_OFS, 32'hFFFF_FFFF);
        reg_rd(8'h08, rd);
        check(rd, 32'h0000_0000);
        foreach (cases[n])
            run_case(cases[n][3], cases[n][2], cases[n][1:0]);
        wrap_up();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED t=%0t run stalled", $time);
        wrap_up();
    end
endmodule : system_clock_source_select_tb_top
